// [core/pin_arbiter_pkg.sv]
// Purpose: Shared constants for the shared pin function arbiter
// Assumes: Six shared port A pins, eight second-port lines
// Notes:   Owner codes are per-pin selectors
package pin_arbiter_pkg;
	localparam int PORTA_WIDTH  = 6;
	localparam int PORTB_WIDTH  = 8;
	localparam int KEYPAD_WIDTH = 6;
	localparam int RESET_PIN    = 3;
	localparam int INPUT_PIN    = 2;
	localparam int CLKOUT_PIN   = 4;
	localparam int CLKIN_PIN    = 5;
	localparam logic [5:0] PORTA_DIR_RESET = 6'h00;
	localparam logic [5:0] PORTA_PULL_RESET = 6'h00;
	localparam logic [7:0] PORTB_DIR_RESET = 8'h00;
	localparam logic [7:0] PORTB_PULL_RESET = 8'h00;
	typedef enum logic [2:0] {
		OWN_GPIO,
		OWN_KEYPAD,
		OWN_TIMER,
		OWN_ANALOG,
		OWN_EXT_IRQ,
		OWN_TIMER_CLK,
		OWN_RESET,
		OWN_OSC
	} owner_t;
endpackage

// [core/shared_pin_function_arbiter.sv]
// Purpose: Decide which on-chip function owns each shared port pin
// Assumes: Pins reach this block as in/out/enable triplets; enables from config logic
// Notes:   Losing functions on a pin are cut off; the gpioPullA pullup select applies unless the owner forces the pullup; sensing lags the pads
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_arbiter #(
	parameter bit LARGE_PACKAGE = 1'b1 // Second port bonded out
) (
	input  wire logic       sys_clk,           // Bus clock, 125 MHz
	input  wire logic       rst,               // Sync reset, active high
	input  wire logic [5:0] portaPinIn,        // Port A pad levels
	output logic      [5:0] portaPinOut,       // Port A pad drive value
	output logic      [5:0] portaPinOe,        // Port A pad drive enable
	output logic      [5:0] portaPullEn,       // Port A pullup enable
	input  wire logic [7:0] portbPinIn,        // Second port pad levels
	output logic      [7:0] portbPinOut,       // Second port drive value
	output logic      [7:0] portbPinOe,        // Second port drive enable
	output logic      [7:0] portbPullEn,       // Second port pullup enable
	input  wire logic [5:0] gpioOutA,          // Port A data from software
	input  wire logic [5:0] gpioDirA,          // Port A direction, 1 = out
	input  wire logic [5:0] gpioPullA,         // Port A pullup select
	output logic      [5:0] gpioInA,           // Port A input to software
	input  wire logic [7:0] gpioOutB,          // Second port data
	input  wire logic [7:0] gpioDirB,          // Second port direction
	input  wire logic [7:0] gpioPullB,         // Second port pullup select
	output logic      [7:0] second_port_lines, // Second port input to software
	input  wire logic [1:0] analogEn,          // Analog channels 0,1 enabled
	input  wire logic [1:0] analogHiEn,        // Analog channels 2,3 enabled
	output logic      [3:0] analogSense,       // Gated pads to converter
	input  wire logic       timerCh0En,        // Timer channel zero enabled
	input  wire logic       timerCh0Oe,        // Timer channel zero drives
	input  wire logic       timerCh0Out,       // Timer channel zero value
	output logic            timer_channel_zero_pin, // Channel zero capture input
	input  wire logic       timerCh1En,        // Timer channel one enabled
	input  wire logic       timerCh1Oe,        // Timer channel one drives
	input  wire logic       timerCh1Out,       // Timer channel one value
	output logic            timer_channel_one_pin,  // Channel one capture input
	input  wire logic       timerClkEn,        // Timer external clock enabled
	output logic            timer_ext_clock_in,     // External timer clock
	input  wire logic [5:0] keypadEn,          // Keypad input enables
	output logic      [5:0] keypadSense,       // Gated keypad inputs
	output logic            keypadWake,        // Keypad wake request
	input  wire logic       extIrqEn,          // External interrupt enabled
	output logic            extIrqSense,       // External interrupt input
	input  wire logic       resetPinEn,        // Reset function on bit 3
	output logic            resetRequest,      // Pin reset request, level
	input  wire logic       oscInEn,           // Oscillator input on bit 5
	output logic            clock_source_in,   // Oscillator input to clock gen
	input  wire logic       oscOutEn,          // Crystal output on bit 4
	input  wire logic       oscOutDrive,       // Crystal amplifier output
	input  wire logic       clock_out_enable,  // Drive internal clock out
	input  wire logic       internalClock,     // Internal oscillator clock
	output logic            clock_source_out   // Bit 4 owned by oscillator
);
	localparam int RP = pin_arbiter_pkg::RESET_PIN;
	localparam int IP = pin_arbiter_pkg::INPUT_PIN;
	localparam int CO = pin_arbiter_pkg::CLKOUT_PIN;
	localparam int CI = pin_arbiter_pkg::CLKIN_PIN;

	// Pad synchronisers; first stage read only by the second
	logic [5:0] syncA1;
	logic [5:0] syncA2;
	logic [7:0] syncB1;
	logic [7:0] syncB2;
	logic [5:0] next_syncA1;
	logic [5:0] next_syncA2;
	logic [7:0] next_syncB1;
	logic [7:0] next_syncB2;

	// Post-reset hold: all port A pins inputs until software touches an enable
	logic armed;
	logic next_armed;

	pin_arbiter_pkg::owner_t owner [6];
	logic [5:0] outVal;
	logic [5:0] outEn;
	logic [5:0] pullSel;
	logic [5:0] next_portaOut;
	logic [5:0] next_portaOe;
	logic [5:0] next_portaPull;
	logic [5:0] next_gpioInA;
	logic [3:0] next_analog;
	logic [5:0] next_keypad;
	logic       next_timer_channel_zero_pin;
	logic       next_timer_channel_one_pin;
	logic       next_timer_ext_clock_in;
	logic       next_irq;
	logic       next_rstReq;
	logic       next_oscIn;
	logic       next_oscOut;
	logic [7:0] next_portbOut;
	logic [7:0] next_portbOe;
	logic [7:0] next_portbPull;
	logic [7:0] next_portbIn;
	logic       anyEnable;
	logic [5:0] keypadOwn;
	logic       next_wake;

	// Direction bits count too: an output port is a function
	assign anyEnable = |{analogEn, analogHiEn, timerCh0En, timerCh1En, timerClkEn, keypadEn,
		extIrqEn, resetPinEn, oscInEn, oscOutEn, clock_out_enable, gpioDirA, gpioDirB};

	always_comb begin
		next_syncA1 = portaPinIn;
		next_syncA2 = syncA1;
		next_syncB1 = portbPinIn;
		next_syncB2 = syncB1;
		next_armed  = armed | anyEnable;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// Pads idle high; a low reset value would fake a reset request
			syncA1 <= 6'h3f;
			syncA2 <= 6'h3f;
			syncB1 <= 8'hff;
			syncB2 <= 8'hff;
			armed  <= 1'b0;
		end else begin
			syncA1 <= next_syncA1;
			syncA2 <= next_syncA2;
			syncB1 <= next_syncB1;
			syncB2 <= next_syncB2;
			armed  <= next_armed;
		end
	end

	// Owner per pin, highest priority first
	always_comb begin
		owner[0] = analogEn[0] ? pin_arbiter_pkg::OWN_ANALOG :
			timerCh0En ? pin_arbiter_pkg::OWN_TIMER :
			keypadEn[0] ? pin_arbiter_pkg::OWN_KEYPAD : pin_arbiter_pkg::OWN_GPIO;
		owner[1] = analogEn[1] ? pin_arbiter_pkg::OWN_ANALOG :
			timerCh1En ? pin_arbiter_pkg::OWN_TIMER :
			keypadEn[1] ? pin_arbiter_pkg::OWN_KEYPAD : pin_arbiter_pkg::OWN_GPIO;
		owner[IP] = extIrqEn ? pin_arbiter_pkg::OWN_EXT_IRQ :
			keypadEn[IP] ? pin_arbiter_pkg::OWN_KEYPAD :
			timerClkEn ? pin_arbiter_pkg::OWN_TIMER_CLK : pin_arbiter_pkg::OWN_GPIO;
		owner[RP] = resetPinEn ? pin_arbiter_pkg::OWN_RESET :
			keypadEn[RP] ? pin_arbiter_pkg::OWN_KEYPAD : pin_arbiter_pkg::OWN_GPIO;
		// Clock-out enable claims bit 4 just as the crystal output does
		owner[CO] = (oscOutEn || clock_out_enable) ? pin_arbiter_pkg::OWN_OSC :
			analogHiEn[0] ? pin_arbiter_pkg::OWN_ANALOG :
			keypadEn[CO] ? pin_arbiter_pkg::OWN_KEYPAD : pin_arbiter_pkg::OWN_GPIO;
		owner[CI] = oscInEn ? pin_arbiter_pkg::OWN_OSC :
			analogHiEn[1] ? pin_arbiter_pkg::OWN_ANALOG :
			keypadEn[CI] ? pin_arbiter_pkg::OWN_KEYPAD : pin_arbiter_pkg::OWN_GPIO;
	end

	// Drive and sensing follow the owner only, losers see nothing; pullup is forced by the owner or else left to gpioPullA
	always_comb begin
		outVal       = 6'h00;
		outEn        = 6'h00;
		pullSel      = gpioPullA;
		next_gpioInA = 6'h00;
		next_keypad  = 6'h00;
		next_analog  = 4'h0;
		next_timer_channel_zero_pin    = 1'b0;
		next_timer_channel_one_pin    = 1'b0;
		next_timer_ext_clock_in    = 1'b0;
		next_irq     = 1'b1;
		next_rstReq  = 1'b0;
		next_oscIn   = 1'b0;
		next_oscOut  = 1'b0;
		keypadOwn    = 6'h00;
		for (int i = 0; i < pin_arbiter_pkg::PORTA_WIDTH; i++) begin
			case (owner[i])
				pin_arbiter_pkg::OWN_GPIO: begin
					next_gpioInA[i] = syncA2[i];
					if (i != IP) begin
						outVal[i] = gpioOutA[i];
						outEn[i]  = gpioDirA[i];
					end
				end
				pin_arbiter_pkg::OWN_KEYPAD: begin
					next_keypad[i] = syncA2[i];
					keypadOwn[i]   = 1'b1;
					pullSel[i]     = 1'b1;
				end
				pin_arbiter_pkg::OWN_TIMER: begin
					if (i == 0) begin
						next_timer_channel_zero_pin = syncA2[i];
						outVal[i] = timerCh0Out;
						outEn[i]  = timerCh0Oe;
					end else begin
						next_timer_channel_one_pin = syncA2[i];
						outVal[i] = timerCh1Out;
						outEn[i]  = timerCh1Oe;
					end
				end
				pin_arbiter_pkg::OWN_ANALOG: begin
					pullSel[i] = 1'b0; // Pullup would skew conversion
					case (i)
						0:       next_analog[0] = syncA2[i];
						1:       next_analog[1] = syncA2[i];
						CO:      next_analog[2] = syncA2[i];
						default: next_analog[3] = syncA2[i];
					endcase
				end
				pin_arbiter_pkg::OWN_EXT_IRQ: begin
					next_irq   = syncA2[i];
					pullSel[i] = gpioPullA[i];
				end
				pin_arbiter_pkg::OWN_TIMER_CLK: next_timer_ext_clock_in = syncA2[i];
				pin_arbiter_pkg::OWN_RESET: begin
					next_rstReq = ~syncA2[i];
					pullSel[i]  = 1'b1;
				end
				pin_arbiter_pkg::OWN_OSC: begin
					pullSel[i] = 1'b0;
					if (i == CO) begin
						next_oscOut = 1'b1;
						outEn[i]    = 1'b1;
						outVal[i]   = clock_out_enable ? internalClock : oscOutDrive;
					end else begin
						next_oscIn = syncA2[i];
					end
				end
				default: next_gpioInA[i] = syncA2[i];
			endcase
		end
		// Only pins the keypad actually owns may wake the device
		next_wake      = |(keypadOwn & ~next_keypad);
		// Fresh out of reset nothing drives, whatever the table says
		next_portaOut  = armed ? outVal : 6'h00;
		next_portaOe   = armed ? outEn : pin_arbiter_pkg::PORTA_DIR_RESET;
		next_portaPull = armed ? pullSel : pin_arbiter_pkg::PORTA_PULL_RESET;
	end

	// Second port: absent in the small package, so never drives there
	always_comb begin
		next_portbOut  = LARGE_PACKAGE ? gpioOutB : 8'h00;
		next_portbOe   = LARGE_PACKAGE ? gpioDirB : 8'h00;
		next_portbPull = LARGE_PACKAGE ? gpioPullB : 8'h00;
		next_portbIn   = LARGE_PACKAGE ? syncB2 : 8'h00;
	end

	// One edge from control inputs to the pads
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			portaPinOut            <= 6'h00;
			portaPinOe             <= pin_arbiter_pkg::PORTA_DIR_RESET;
			portaPullEn            <= pin_arbiter_pkg::PORTA_PULL_RESET;
			gpioInA                <= 6'h00;
			analogSense            <= 4'h0;
			keypadSense            <= 6'h00;
			keypadWake             <= 1'b0;
			timer_channel_zero_pin <= 1'b0;
			timer_channel_one_pin  <= 1'b0;
			timer_ext_clock_in     <= 1'b0;
			extIrqSense            <= 1'b1;
			resetRequest           <= 1'b0;
			clock_source_in        <= 1'b0;
			clock_source_out       <= 1'b0;
		end else begin
			portaPinOut            <= next_portaOut;
			portaPinOe             <= next_portaOe;
			portaPullEn            <= next_portaPull;
			gpioInA                <= next_gpioInA;
			analogSense            <= next_analog;
			keypadSense            <= next_keypad;
			keypadWake             <= next_wake;
			timer_channel_zero_pin <= next_timer_channel_zero_pin;
			timer_channel_one_pin  <= next_timer_channel_one_pin;
			timer_ext_clock_in     <= next_timer_ext_clock_in;
			extIrqSense            <= next_irq;
			resetRequest           <= next_rstReq;
			clock_source_in        <= next_oscIn;
			clock_source_out       <= next_oscOut;
		end
	end

	// Second port registered apart; it carries no shared function
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			portbPinOut       <= 8'h00;
			portbPinOe        <= pin_arbiter_pkg::PORTB_DIR_RESET;
			portbPullEn       <= pin_arbiter_pkg::PORTB_PULL_RESET;
			second_port_lines <= 8'h00;
		end else begin
			portbPinOut       <= next_portbOut;
			portbPinOe        <= next_portbOe;
			portbPullEn       <= next_portbPull;
			second_port_lines <= next_portbIn;
		end
	end
endmodule
`default_nettype wire

// [bench/pad_model.sv]
// Purpose: Pad level model for one group of shared pins
// Assumes: Design drive wins, then external drive, then pullup
// Notes:   Floating pads toggle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module pad_model #(
	parameter int W = 6 // Pins in the group
) (
	input  wire logic         sys_clk,  // Bench clock
	input  wire logic [W-1:0] pinOut,   // Design drive value
	input  wire logic [W-1:0] pinOe,    // Design drive enable
	input  wire logic [W-1:0] pullEn,   // Design pullup enable
	input  wire logic [W-1:0] extLevel, // Board drive value
	input  wire logic [W-1:0] extEn,    // Board drive enable
	output logic      [W-1:0] padLevel  // Resolved pad level
);
	logic [W-1:0] floatPat = '0;
	always @(posedge sys_clk) begin
		floatPat <= ~floatPat;
	end
	assign padLevel = (pinOe & pinOut) | (~pinOe & extEn & extLevel)
		| (~pinOe & ~extEn & (pullEn | floatPat));
endmodule
`default_nettype wire

// [bench/pin_arbiter_assertions.sv]
// Purpose: Port-level properties of the shared pin arbiter
// Assumes: Bound to the arbiter top, one clock domain
// Notes:   Sensed values lag the pads by three edges
`timescale 1ns/1ps
`default_nettype none
module pin_arbiter_assertions (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [5:0] portaPinIn,
	input wire logic [5:0] portaPinOut,
	input wire logic [5:0] portaPinOe,
	input wire logic [5:0] portaPullEn,
	input wire logic [5:0] gpioDirA,
	input wire logic [1:0] analogEn,
	input wire logic       timerCh0En,
	input wire logic       timerCh0Oe,
	input wire logic [5:0] keypadEn,
	input wire logic       extIrqEn,
	input wire logic       extIrqSense,
	input wire logic       resetPinEn,
	input wire logic       resetRequest,
	input wire logic       oscOutEn,
	input wire logic       clock_out_enable,
	input wire logic       internalClock,
	input wire logic       clock_source_out,
	input wire logic       keypadWake
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	reset_quiet_a: assert property ($past(rst) |-> portaPinOe == 6'h00 && portaPullEn == 6'h00)
		else $error("pins active after reset");
	input_only_a: assert property (portaPinOe[2] == 1'b0)
		else $error("input-only pin driven");
	bit0_drive_a: assert property (portaPinOe[0] |-> !$past(analogEn[0]) && ($past(timerCh0En) ?
		$past(timerCh0Oe) : !$past(keypadEn[0]) && $past(gpioDirA[0]))) else $error("bit0 owner");
	clk_out_a: assert property (portaPinOe[4] && $past(clock_out_enable) |->
		portaPinOut[4] == $past(internalClock)) else $error("clock out value");
	osc_owner_a: assert property (clock_source_out |-> $past(oscOutEn) || $past(clock_out_enable))
		else $error("oscillator owner");
	osc_pull_a: assert property (portaPullEn[4] |-> !$past(oscOutEn) && !$past(clock_out_enable))
		else $error("pullup under oscillator");
	reset_req_a: assert property (resetRequest |-> $past(resetPinEn) && !$past(portaPinIn[3], 3))
		else $error("spurious reset request");
	irq_sense_a: assert property (!extIrqSense |-> $past(extIrqEn) && !$past(portaPinIn[2], 3))
		else $error("spurious interrupt level");
	wake_src_a: assert property (keypadWake |-> ($past(keypadEn) & ~$past(portaPinIn, 3)) != 6'h00)
		else $error("wake without low keypad pin");
	cover property (resetRequest);
	cover property (portaPinOe[4] && clock_source_out);
	cover property (keypadWake);
endmodule
bind shared_pin_function_arbiter pin_arbiter_assertions pin_arbiter_assertions_inst (
	.sys_clk(sys_clk), .rst(rst), .portaPinIn(portaPinIn), .portaPinOut(portaPinOut),
	.portaPinOe(portaPinOe), .portaPullEn(portaPullEn), .gpioDirA(gpioDirA),
	.analogEn(analogEn), .timerCh0En(timerCh0En), .timerCh0Oe(timerCh0Oe),
	.keypadEn(keypadEn), .extIrqEn(extIrqEn), .extIrqSense(extIrqSense),
	.resetPinEn(resetPinEn), .resetRequest(resetRequest), .oscOutEn(oscOutEn),
	.clock_out_enable(clock_out_enable), .internalClock(internalClock),
	.clock_source_out(clock_source_out), .keypadWake(keypadWake));
`default_nettype wire

// [bench/tb_shared_pin_function_arbiter.sv]
// Purpose: Random and corner tests of pin ownership
// Assumes: Pads resolved by pad_model, inputs held 7 cycles
// Notes:   Pullups follow the owner, else the software select
`timescale 1ns/1ps
`default_nettype none
module tb_shared_pin_function_arbiter;
	logic sys_clk = 1'b0, rst = 1'b1;
	logic [5:0] portaPinIn, portaPinOut, portaPinOe, portaPullEn, gpioOutA, gpioDirA, gpioPullA;
	logic [5:0] gpioInA, keypadEn, keypadSense, extA, extEnA = 6'h3f;
	logic [7:0] portbPinIn, portbPinOut, portbPinOe, portbPullEn, gpioOutB, gpioDirB, gpioPullB;
	logic [7:0] second_port_lines, extB;
	logic [1:0] analogEn, analogHiEn;
	logic [3:0] analogSense;
	logic timerCh0En, timerCh0Oe, timerCh0Out, timer_channel_zero_pin, timerCh1En, timerCh1Oe;
	logic timerCh1Out, timer_channel_one_pin, timerClkEn, timer_ext_clock_in, keypadWake;
	logic extIrqEn, extIrqSense, resetPinEn, resetRequest, oscInEn, clock_source_in, oscOutEn;
	logic oscOutDrive, clock_out_enable, internalClock, clock_source_out;
	logic [79:0] stim = '0;
	logic [95:0] r;
	int failures = 0, tests_run = 0;
	assign {gpioOutA, gpioDirA, gpioPullA, gpioOutB, gpioDirB, gpioPullB, analogEn, analogHiEn,
		timerCh0En, timerCh0Oe, timerCh0Out, timerCh1En, timerCh1Oe, timerCh1Out, timerClkEn,
		keypadEn, extIrqEn, resetPinEn, oscInEn, oscOutEn, oscOutDrive, clock_out_enable,
		internalClock, extA, extB} = stim;
	shared_pin_function_arbiter shared_pin_function_arbiter_inst (.sys_clk(sys_clk), .rst(rst),
		.portaPinIn(portaPinIn), .portaPinOut(portaPinOut), .portaPinOe(portaPinOe),
		.portaPullEn(portaPullEn), .portbPinIn(portbPinIn), .portbPinOut(portbPinOut),
		.portbPinOe(portbPinOe), .portbPullEn(portbPullEn), .gpioOutA(gpioOutA),
		.gpioDirA(gpioDirA), .gpioPullA(gpioPullA), .gpioInA(gpioInA), .gpioOutB(gpioOutB),
		.gpioDirB(gpioDirB), .gpioPullB(gpioPullB), .second_port_lines(second_port_lines),
		.analogEn(analogEn), .analogHiEn(analogHiEn), .analogSense(analogSense),
		.timerCh0En(timerCh0En), .timerCh0Oe(timerCh0Oe), .timerCh0Out(timerCh0Out),
		.timer_channel_zero_pin(timer_channel_zero_pin), .timerCh1En(timerCh1En),
		.timerCh1Oe(timerCh1Oe), .timerCh1Out(timerCh1Out),
		.timer_channel_one_pin(timer_channel_one_pin), .timerClkEn(timerClkEn),
		.timer_ext_clock_in(timer_ext_clock_in), .keypadEn(keypadEn), .keypadSense(keypadSense),
		.keypadWake(keypadWake), .extIrqEn(extIrqEn), .extIrqSense(extIrqSense),
		.resetPinEn(resetPinEn), .resetRequest(resetRequest), .oscInEn(oscInEn),
		.clock_source_in(clock_source_in), .oscOutEn(oscOutEn), .oscOutDrive(oscOutDrive),
		.clock_out_enable(clock_out_enable), .internalClock(internalClock),
		.clock_source_out(clock_source_out));
	pad_model #(.W(6)) pad_model_inst (.sys_clk(sys_clk), .pinOut(portaPinOut), .pinOe(portaPinOe),
		.pullEn(portaPullEn), .extLevel(extA), .extEn(extEnA), .padLevel(portaPinIn));
	pad_model #(.W(8)) pad_model_b_inst (.sys_clk(sys_clk), .pinOut(portbPinOut),
		.pinOe(portbPinOe),
		.pullEn(portbPullEn), .extLevel(extB), .extEn(8'hff), .padLevel(portbPinIn));
	always #4 sys_clk = ~sys_clk;
	function automatic int owner(input int b);
		case (b)
			0: return analogEn[0] ? 3 : timerCh0En ? 2 : keypadEn[0] ? 1 : 0;
			1: return analogEn[1] ? 3 : timerCh1En ? 2 : keypadEn[1] ? 1 : 0;
			2: return extIrqEn ? 4 : keypadEn[2] ? 1 : timerClkEn ? 5 : 0;
			3: return resetPinEn ? 6 : keypadEn[3] ? 1 : 0;
			4: return (oscOutEn | clock_out_enable) ? 7 : analogHiEn[0] ? 3 : keypadEn[4] ? 1 : 0;
			default: return oscInEn ? 7 : analogHiEn[1] ? 3 : keypadEn[5] ? 1 : 0;
		endcase
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic verify();
		logic [5:0] eOe, eOut, pad, ePull, kOwn, gOwn, aOwn;
		int o;
		for (int b = 0; b < 6; b++) begin
			o = owner(b);
			eOe[b] = o == 0 ? (b != 2 && gpioDirA[b]) : o == 2 ? (b == 0 ? timerCh0Oe : timerCh1Oe)
				: (o == 7 && b == 4);
			eOut[b] = o == 0 ? gpioOutA[b] : o == 2 ? (b == 0 ? timerCh0Out : timerCh1Out)
				: (clock_out_enable ? internalClock : oscOutDrive);
			pad[b] = eOe[b] ? eOut[b] : extEnA[b] ? extA[b] : 1'b1;
			ePull[b] = (o == 1 || o == 6) ? 1'b1 : (o == 3 || o == 7) ? 1'b0 : gpioPullA[b];
			kOwn[b] = o == 1;
			gOwn[b] = o == 0;
			aOwn[b] = o == 3;
		end
		check({2'h0, portaPinOe}, {2'h0, eOe});
		check({2'h0, portaPinOut & eOe}, {2'h0, eOut & eOe});
		check({2'h0, portaPullEn}, {2'h0, ePull});
		check({2'h0, gpioInA}, {2'h0, pad & gOwn});
		check({2'h0, keypadSense}, {2'h0, pad & kOwn});
		check({4'h0, analogSense}, {4'h0, pad[5:4] & aOwn[5:4], pad[1:0] & aOwn[1:0]});
		check({4'h0, extIrqSense, resetRequest, keypadWake, clock_source_out}, {4'h0,
			owner(2) == 4 ? pad[2] : 1'b1, owner(3) == 6 && !pad[3], |(kOwn & ~pad), owner(4) == 7});
		check({4'h0, timer_channel_zero_pin, timer_channel_one_pin, timer_ext_clock_in,
			clock_source_in}, {4'h0, owner(0) == 2 && pad[0], owner(1) == 2 && pad[1],
			owner(2) == 5 && pad[2], owner(5) == 7 && pad[5]});
		check(portbPinOe, gpioDirB);
		check(portbPinOut, gpioOutB);
		check(portbPullEn, gpioPullB);
		check(second_port_lines, (gpioDirB & gpioOutB) | (~gpioDirB & extB));
	endtask
	task automatic reset_check();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check({2'h0, portaPinOe}, 8'h00);
		check({2'h0, portaPullEn}, 8'h00);
		check({7'h0, extIrqSense}, 8'h01);
		@(posedge sys_clk);
		rst <= 1'b0;
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		void'($urandom(74694));
		// Enables live during reset, so reset alone must keep pins quiet
		r = {$urandom, $urandom, $urandom};
		stim = r[79:0];
		repeat (7) @(posedge sys_clk);
		reset_check();
		for (int i = 0; i < 60; i++) begin
			r = {$urandom, $urandom, $urandom};
			// Released reset pad must read high through the forced pullup
			if (i % 10 == 9)
				r[19] = 1'b1;
			@(posedge sys_clk);
			stim <= r[79:0];
			extEnA <= (i % 10 == 9) ? 6'h37 : 6'h3f;
			repeat (6) @(posedge sys_clk);
			@(negedge sys_clk);
			verify();
			if (i == 30)
				reset_check();
		end
		close_out();
	end
	initial begin
		#40000;
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
